// File: common/jtx_pkg.sv
package jtx_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PE = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  // control register field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SCR_BIT = 1;
  localparam int CTRL_SC1_BIT = 2;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_KM1_LSB = 16;
  localparam int MODE_W = 5;
  localparam int KM1_W = 5;
  localparam int PE_W = 4;
  // reset values: disabled, subclass 1, mode 0, K = 32
  localparam logic [31:0] CTRL_RST = 32'h001f_0004;
  localparam logic [3:0] PE_RST = 4'h0;
  // status register field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SYNC_BIT = 4;
  localparam int STAT_SREF_BIT = 5;
  localparam int STAT_DUAL_BIT = 6;
  localparam int STAT_LANES_LSB = 8;
  localparam int STAT_F_LSB = 16;
  localparam int STAT_DEC_LSB = 24;
  // lane rate ceiling in Mbps
  localparam int LANE_RATE_MAX_MBPS = 12800;
  // control characters (octet value with k flag set)
  localparam logic [7:0] K_R = 8'h1c;
  localparam logic [7:0] K_A = 8'h7c;
  localparam logic [7:0] K_Q = 8'h9c;
  localparam logic [7:0] K_COMMA = 8'hbc;
  localparam logic [7:0] K_F = 8'hfc;
  localparam logic [7:0] SCR_ALIGN_VAL = 8'hfc;
  // alignment sequence length in multiframes, minus one
  localparam logic [1:0] ILAS_LAST_MF = 2'h3;
  localparam logic [7:0] ILAS_CFG_END = 8'h08;
  localparam logic [14:0] SCR_SEED = 15'h7fff;
  typedef enum logic [2:0] {ST_OFF, ST_SYSREF, ST_CGS, ST_WAIT, ST_ILAS, ST_DATA} jtx_state_e;
endpackage : jtx_pkg

// File: hdl/jtx_enc8b10b.sv
`timescale 1ns/1ps
`default_nettype none
// 8b/10b encoder, output {abcdei,fghj}, a sent first; k input supports K28.y only
module jtx_enc8b10b (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic kin,
  input wire logic [7:0] din,
  output logic [9:0] dout
);
  // negative-disparity codes
  localparam logic [5:0] T6 [32] = '{
    6'b100111, 6'b011101, 6'b101101, 6'b110001, 6'b110101, 6'b101001, 6'b011001, 6'b111000,
    6'b111001, 6'b100101, 6'b010101, 6'b110100, 6'b001101, 6'b101100, 6'b011100, 6'b010111,
    6'b011011, 6'b100011, 6'b010011, 6'b110010, 6'b001011, 6'b101010, 6'b011010, 6'b111010,
    6'b110011, 6'b100110, 6'b010110, 6'b110110, 6'b001110, 6'b101110, 6'b011110, 6'b101011};
  localparam logic [3:0] T4 [8] = '{
    4'b1011, 4'b1001, 4'b0101, 4'b1100, 4'b1101, 4'b1010, 4'b0110, 4'b1110};
  logic rd_r;
  logic [5:0] c6_m;
  logic [3:0] c4_m;
  logic unb6;
  logic unb4;
  logic rd6;
  logic a7;
  logic comp4;
  logic [4:0] x;
  logic [2:0] y;

  // 5b/6b then 3b/4b, disparity carried between them
  always_comb begin
    x = din[4:0];
    y = din[7:5];
    c6_m = kin ? 6'b001111 : T6[x];
    unb6 = $countones(c6_m) != 3;
    rd6 = rd_r ^ unb6;
    // alternate 7 avoids a run of five in data, always used by K28.7
    a7 = (y == 3'h7) && (kin || (!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
         || (rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
    c4_m = a7 ? 4'b0111 : T4[y];
    unb4 = $countones(c4_m) != 2;
    if (kin && !unb4 && y != 3'h3) begin
      comp4 = !rd6;
    end else begin
      comp4 = rd6 && (unb4 || y == 3'h3);
    end
  end

  // rd_r high means running disparity positive
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_r <= 1'b0;
      dout <= 10'h000;
    end else if (clr) begin
      rd_r <= 1'b0;
      dout <= 10'h000;
    end else begin
      rd_r <= rd6 ^ unb4;
      dout[9:4] <= (rd_r && (unb6 || (!kin && x == 5'd7))) ? ~c6_m : c6_m;
      dout[3:0] <= comp4 ? ~c4_m : c4_m;
    end
  end
endmodule : jtx_enc8b10b
`default_nettype wire

// File: hdl/jtx_link_tx.sv
`timescale 1ns/1ps
`default_nettype none
// Rules from the document, tagged where the code serves them
// [R1] up to 12.8 Gbps over sixteen lanes
// [R2] receiver pulls sync low to start
// [R3] sysref resets local multiframe counter
// [R4] mode and K alone fix mapping
// [R5] scramble octets only when enabled
// [R6] alignment sequence never scrambled
// [R7] comma stream only after sysref processed; the code already sends commas while waiting in ST_SYSREF
// [R8] comma characters while sync held low
// [R9] receiver releases sync after four commas
// [R10] wait for multiframe edge after sync release
// [R11] alignment sequence spans four multiframes
// [R12] second multiframe carries link configuration
// [R13] receiver buffers lanes until all arrive
// [R14] every octet coded 8b/10b
// [R15] unscrambled repeat frame end becomes F/A
// [R16] scrambled 0xfc frame end becomes F/A
// [R17] receiver checks and restores alignment characters
// [R18] pre-emphasis field sets output equalization
// [R19] software disables link before reprogramming
// [R20] enable low holds link in reset
// [R21] receiver picks elastic release point
// [R22] receiver releases only when all arrived
// [R23] subclass 0 self-generates multiframe clock
// [R24] link mode derives remaining link parameters
// [R25] sync low in data restarts sync
// [R26] all lanes start alignment together
module jtx_link_tx
  import jtx_pkg::*;
#(
  parameter int LANES = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sync_request_single_ended_n,
  input wire logic sysref,
  input wire logic [LANES*8-1:0] sample_octets,
  output logic sample_ready,
  output logic [LANES*5-1:0] lane_group_a,
  output logic [LANES*5-1:0] lane_group_b,
  output logic [LANES-1:0] serializer_pd,
  output logic [PE_W-1:0] serializer_preemphasis
);
  logic [31:0] ctrl_r;
  logic [PE_W-1:0] pe_r;
  logic ap_vld_r;
  logic ap_wr_r;
  logic ap_word_r;
  logic [7:0] ap_addr_r;
  logic rd_done_r;
  logic rd_stall;
  logic take;
  logic [31:0] rmux;
  logic link_enable;
  logic scramble_enable;
  logic sc1;
  logic [MODE_W-1:0] link_mode_select;
  logic [KM1_W-1:0] km1;
  logic [2:0] sync_s_r;
  logic [2:0] sref_s_r;
  logic sync_lvl_r;
  logic sref_lvl_r;
  logic sref_prev_r;
  logic sref_rise;
  logic sref_seen_r;
  logic [3:0] oct_r;
  logic [KM1_W-1:0] frm_r;
  logic [7:0] mf_pos_r;
  logic [3:0] f_oct;
  logic [4:0] lanes_act;
  logic dual_ch;
  logic [2:0] dec_code;
  logic fr_end;
  logic mf_end;
  logic [1:0] ilas_mf_r;
  jtx_state_e st_r;
  jtx_state_e st_nxt;
  logic [LANES*10-1:0] lane_sym;

  // control fields
  assign link_enable = ctrl_r[CTRL_EN_BIT];
  assign scramble_enable = ctrl_r[CTRL_SCR_BIT];
  assign sc1 = ctrl_r[CTRL_SC1_BIT];
  assign link_mode_select = ctrl_r[CTRL_MODE_LSB +: MODE_W];
  assign km1 = ctrl_r[CTRL_KM1_LSB +: KM1_W];
  assign serializer_preemphasis = pe_r; // [R18]

  // mode table: lanes, octets per frame, channel count, decimation
  always_comb begin
    lanes_act = 5'(LANES >> link_mode_select[1:0]); // [R1] [R4] [R24]
    f_oct = 4'(4'h1 << link_mode_select[3:2]); // [R4] [R24]
    dual_ch = link_mode_select[4]; // [R24]
    dec_code = dual_ch ? {1'b0, link_mode_select[3:2]} : 3'h0; // [R24]
  end

  // ahb-lite slave: zero-wait writes, one wait state on reads
  assign take = hsel && hready && htrans[1];
  assign rd_stall = ap_vld_r && !ap_wr_r && !rd_done_r;
  assign hreadyout = !rd_stall;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_vld_r <= 1'b0;
      ap_wr_r <= 1'b0;
      ap_word_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else if (hreadyout) begin
      ap_vld_r <= take;
      ap_wr_r <= hwrite;
      ap_word_r <= hsize == 3'h2;
      ap_addr_r <= haddr[7:0];
    end
  end

  // read wait cycle lets a preceding write land first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_done_r <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      rd_done_r <= rd_stall;
      if (rd_stall) begin
        hrdata <= rmux;
      end
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rmux = 32'h0000_0000;
    case (ap_addr_r)
      OFF_CTRL: rmux = ctrl_r;
      OFF_PE: rmux[PE_W-1:0] = pe_r;
      OFF_STAT: begin
        rmux[STAT_STATE_LSB +: 3] = st_r;
        rmux[STAT_SYNC_BIT] = sync_lvl_r;
        rmux[STAT_SREF_BIT] = sref_seen_r;
        rmux[STAT_DUAL_BIT] = dual_ch;
        rmux[STAT_LANES_LSB +: 5] = lanes_act;
        rmux[STAT_F_LSB +: 4] = f_oct;
        rmux[STAT_DEC_LSB +: 3] = dec_code;
      end
      default: rmux = 32'h0000_0000;
    endcase
  end

  // register writes, word size only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RST;
      pe_r <= PE_RST;
    end else if (ap_vld_r && ap_wr_r && ap_word_r) begin
      if (ap_addr_r == OFF_CTRL) begin
        ctrl_r <= {11'h000, hwdata[20:16], 3'h0, hwdata[12:8], 5'h00, hwdata[2:0]};
      end
      if (ap_addr_r == OFF_PE) begin
        pe_r <= hwdata[PE_W-1:0]; // [R18]
      end
    end
  end

  // pin synchronisers: level changes once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_s_r <= 3'h7;
      sref_s_r <= 3'h0;
      sync_lvl_r <= 1'b1;
      sref_lvl_r <= 1'b0;
      sref_prev_r <= 1'b0;
    end else begin
      sync_s_r <= {sync_s_r[1:0], sync_request_single_ended_n};
      sref_s_r <= {sref_s_r[1:0], sysref};
      if (sync_s_r[1] == sync_s_r[2]) begin
        sync_lvl_r <= sync_s_r[2]; // [R2]
      end
      if (sref_s_r[1] == sref_s_r[2]) begin
        sref_lvl_r <= sref_s_r[2];
      end
      sref_prev_r <= sref_lvl_r;
    end
  end

  assign sref_rise = sref_lvl_r && !sref_prev_r;

  // local multiframe counter; free running in subclass 0
  assign fr_end = oct_r == f_oct - 4'h1;
  assign mf_end = fr_end && frm_r == km1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oct_r <= 4'h0;
      frm_r <= '0;
      mf_pos_r <= 8'h00;
    end else if (!link_enable) begin
      oct_r <= 4'h0; // [R20]
      frm_r <= '0;
      mf_pos_r <= 8'h00;
    end else if (sc1 && sref_rise) begin
      oct_r <= 4'h0; // [R3]
      frm_r <= '0;
      mf_pos_r <= 8'h00;
    end else begin
      // [R23] no sysref needed: phase is wherever enable left it
      oct_r <= fr_end ? 4'h0 : oct_r + 4'h1;
      mf_pos_r <= mf_end ? 8'h00 : mf_pos_r + 8'h01;
      if (mf_end) begin
        frm_r <= '0;
      end else if (fr_end) begin
        frm_r <= frm_r + 1'b1;
      end
    end
  end

  // sysref processed flag, only meaningful in subclass 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sref_seen_r <= 1'b0;
    end else if (!link_enable) begin
      sref_seen_r <= 1'b0;
    end else if (sref_rise) begin
      sref_seen_r <= 1'b1; // [R3]
    end
  end

  // link state machine
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF: st_nxt = sc1 ? ST_SYSREF : ST_CGS; // [R23]
      ST_SYSREF: if (sref_seen_r) st_nxt = ST_CGS; // [R7]
      ST_CGS: if (sync_lvl_r) st_nxt = ST_WAIT; // [R8]
      ST_WAIT: if (mf_end) st_nxt = ST_ILAS; // [R10] [R26]
      ST_ILAS: if (mf_end && ilas_mf_r == ILAS_LAST_MF) st_nxt = ST_DATA; // [R11]
      ST_DATA: st_nxt = ST_DATA;
      default: st_nxt = ST_OFF;
    endcase
    // renewed request abandons alignment or data
    if ((st_r == ST_WAIT || st_r == ST_ILAS || st_r == ST_DATA) && !sync_lvl_r) begin
      st_nxt = ST_CGS; // [R25]
    end
    if (!link_enable) begin
      st_nxt = ST_OFF; // [R20]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // multiframe index inside the alignment sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ilas_mf_r <= 2'h0;
    end else if (st_r != ST_ILAS) begin
      ilas_mf_r <= 2'h0;
    end else if (mf_end) begin
      ilas_mf_r <= ilas_mf_r + 2'h1; // [R11]
    end
  end

  assign sample_ready = st_r == ST_DATA;

  // per-lane datapath: scramble, align-character insert, encode
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [7:0] raw;
    logic [7:0] scr_o;
    logic [7:0] dat;
    logic [7:0] last_r;
    logic [7:0] oct_c;
    logic k_c;
    logic act;

    assign raw = sample_octets[i*8 +: 8];
    assign act = 5'(i) < lanes_act;
    assign dat = scramble_enable ? scr_o : raw; // [R5]

    // scrambler is held at seed outside data, so alignment octets bypass it
    jtx_scramble u_scr (
      .clk(hclk),
      .rstn(hresetn),
      .clr(st_r != ST_DATA), // [R6]
      .adv(scramble_enable),
      .din(raw),
      .dout(scr_o)
    );

    // previous frame's last octet for repeat detection
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        last_r <= 8'h00;
      end else if (st_r != ST_DATA) begin
        last_r <= 8'h00;
      end else if (fr_end) begin
        last_r <= dat;
      end
    end

    // octet selection per link state
    always_comb begin
      oct_c = K_COMMA;
      k_c = 1'b1;
      case (st_r)
        ST_ILAS: begin
          k_c = 1'b0;
          oct_c = mf_pos_r; // [R6]
          if (mf_pos_r == 8'h00) begin
            oct_c = K_R;
            k_c = 1'b1;
          end else if (mf_end) begin
            oct_c = K_A;
            k_c = 1'b1;
          end else if (ilas_mf_r == 2'h1 && mf_pos_r == 8'h01) begin
            oct_c = K_Q; // [R12]
            k_c = 1'b1;
          end else if (ilas_mf_r == 2'h1 && mf_pos_r < ILAS_CFG_END) begin
            // configuration octets for the receiver's cross-check
            case (mf_pos_r[2:0])
              3'h2: oct_c = 8'(i); // [R12]
              3'h3: oct_c = {3'h0, lanes_act - 5'h01};
              3'h4: oct_c = {4'h0, f_oct - 4'h1};
              3'h5: oct_c = {3'h0, km1};
              3'h6: oct_c = {scramble_enable, sc1, 1'b0, link_mode_select};
              default: oct_c = {4'h0, pe_r};
            endcase
          end
        end
        ST_DATA: begin
          oct_c = dat;
          k_c = 1'b0;
          if (fr_end && (scramble_enable ? dat == SCR_ALIGN_VAL : dat == last_r)) begin
            oct_c = mf_end ? K_A : K_F; // [R15] [R16]
            k_c = 1'b1;
          end
        end
        default: begin
          oct_c = K_COMMA; // [R8]
          k_c = 1'b1;
        end
      endcase
    end

    jtx_enc8b10b u_enc (
      .clk(hclk),
      .rstn(hresetn),
      .clr(!link_enable || !act || st_r == ST_OFF), // [R20]
      .kin(k_c),
      .din(oct_c), // [R14]
      .dout(lane_sym[i*10 +: 10])
    );

    // idle and disabled lanes keep their serializer down
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        serializer_pd[i] <= 1'b1;
      end else begin
        serializer_pd[i] <= !link_enable || !act; // [R20]
      end
    end
  end

  assign lane_group_a = lane_sym[LANES*5-1:0];
  assign lane_group_b = lane_sym[LANES*10-1:LANES*5];
endmodule : jtx_link_tx
`default_nettype wire

// File: hdl/jtx_scramble.sv
`timescale 1ns/1ps
`default_nettype none
// self-synchronous 1 + x^14 + x^15 scrambler, one octet per clock, msb first
module jtx_scramble
  import jtx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic adv,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  logic [14:0] st_r;
  logic [14:0] st_nxt;

  // bit-serial recurrence unrolled over the octet
  always_comb begin
    logic b;
    b = 1'b0;
    st_nxt = st_r;
    dout = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = din[i] ^ st_nxt[13] ^ st_nxt[14];
      dout[i] = b;
      st_nxt = {st_nxt[13:0], b};
    end
  end

  // state only moves on octets actually sent scrambled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= SCR_SEED;
    end else if (clr) begin
      st_r <= SCR_SEED;
    end else if (adv) begin
      st_r <= st_nxt;
    end
  end
endmodule : jtx_scramble
`default_nettype wire

// File: testbench/jtx_link_tx_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level watch of bus timing and link behaviour
module jtx_chk
  import jtx_pkg::*;
#(
  parameter int LANES = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic sync_request_single_ended_n,
  input wire logic sample_ready,
  input wire logic [LANES*5-1:0] lane_group_a,
  input wire logic [LANES-1:0] serializer_pd,
  input wire logic [PE_W-1:0] serializer_preemphasis
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_go;
  logic wr_go;
  logic [3:0] low_cnt_r;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = hsel && hready && htrans[1] && hwrite;
  // saturating count of sync-low cycles; the pin filter needs several
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_r <= 4'h0;
    end else if (sync_request_single_ended_n) begin
      low_cnt_r <= 4'h0;
    end else if (low_cnt_r != 4'hf) begin
      low_cnt_r <= low_cnt_r + 4'h1;
    end
  end
  // a read costs exactly one wait state
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    rd_go |=> s_rd_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_zero;
    wr_go |=> hreadyout;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_hold_rd;
    $changed(hrdata) |-> $past(!hreadyout);
  endproperty
  a_hold_rd: assert property (p_hold_rd) else $error("read data moved outside a read");
  property p_pe_write;
    $changed(serializer_preemphasis) |-> $past(wr_go, 2) || $past(wr_go, 3);
  endproperty
  a_pe_write: assert property (p_pe_write) else $error("pre-emphasis moved without write");
  property p_comma;
    low_cnt_r == 4'hf |-> lane_group_a[9:0] inside {10'h000, 10'h0fa, 10'h305};
  endproperty
  a_comma: assert property (p_comma) else $error("no comma while sync held");
  property p_resync;
    sample_ready && !sync_request_single_ended_n |-> ##[1:8] !sample_ready;
  endproperty
  a_resync: assert property (p_resync) else $error("data kept after sync request");
  property p_pd_idle;
    serializer_pd[0] [*3] |-> lane_group_a[9:0] == 10'h000;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("powered-down lane active");
  property p_idle_pd;
    &serializer_pd |-> !sample_ready;
  endproperty
  a_idle_pd: assert property (p_idle_pd) else $error("data taken while disabled");
endmodule : jtx_chk
`default_nettype wire

// File: testbench/jtx_link_tx_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module jtx_link_tx_tb_top;
  import jtx_pkg::*;
  logic hclk, hresetn, hsel, hwrite, sysref, hold, rnd_on;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [127:0] sample_octets;
  wire hready, hreadyout, hresp, sample_ready, sync_n, rx_rel;
  wire [31:0] hrdata;
  wire [79:0] grp_a, grp_b;
  wire [15:0] pd;
  wire [3:0] pe;
  int bad_count, num_checks, cycles, seed, n_k0, n_k4, i, na;
  int m_ctrl, m_pe;
  assign hready = hreadyout;
  jtx_link_tx #(.LANES(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sync_request_single_ended_n(sync_n), .sysref(sysref), .sample_octets(sample_octets),
    .sample_ready(sample_ready), .lane_group_a(grp_a), .lane_group_b(grp_b), .serializer_pd(pd),
    .serializer_preemphasis(pe));
  jtx_rx_model #(.KLEN(4), .RBD(0)) rx (.clk(hclk), .rstn(hresetn), .hold(hold), .sym(grp_a[9:0]),
    .sync_n(sync_n), .released(rx_rel));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // random payload once enabled, zero payload before that
  always @(posedge hclk) sample_octets <= rnd_on ? {4{$random(seed)}} : 128'h0;
  // hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      wrap_up();
    end
  end
  // count alignment markers on lane 0, sampled away from the edge
  always @(negedge hclk) begin
    if (grp_a[9:0] inside {10'h0f4, 10'h30b}) n_k0++;
    if (grp_a[9:0] inside {10'h0f2, 10'h30d}) n_k4++;
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  // single word transfer; waits on hready rather than a fixed count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(negedge hclk); while (hready !== 1'b1);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge hclk); while (hready !== 1'b1);
    @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  task automatic wait_data();
    for (int j = 0; j < 400 && sample_ready !== 1'b1; j++) @(negedge hclk);
  endtask : wait_data
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial begin
    seed = 32'h28b0c79f;
    {hresetn, hsel, hwrite, sysref, rnd_on} = 5'h0;
    hold = 1'b1;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    sample_octets = 128'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, read-back, unmapped place
    m_ctrl = CTRL_RST;
    m_pe = ($random(seed) & 7) | 8;
    ahb(1'b0, OFF_CTRL, 0);
    chk("ctrl", rd, m_ctrl);
    chk("pd", pd, 16'hffff);
    ahb(1'b1, OFF_PE, m_pe);
    ahb(1'b1, 8'h10, 32'hffffffff);
    ahb(1'b0, OFF_PE, 0);
    chk("pe", rd, m_pe);
    chk("pe pin", pe, m_pe);
    ahb(1'b0, 8'h10, 0);
    chk("unmapped", rd, 0);
    $display("registers test done");
    // every mode code with the link held off
    for (i = 0; i < 32; i++) begin
      ahb(1'b1, OFF_CTRL, 32'h0003_0000 | (i << 8));
      ahb(1'b0, OFF_STAT, 0);
      chk("lanes", rd[12:8], 16 >> (i % 4));
      chk("f", rd[19:16], 1 << ((i / 4) % 4));
      chk("dual", rd[6], i / 16);
      chk("dec", rd[26:24], (i / 16) * ((i / 4) % 4));
    end
    $display("mode table test done");
    // subclass 1 link-up: four lanes, F 1, K 4, unscrambled zero payload
    ahb(1'b1, OFF_CTRL, 32'h0003_0205);
    ahb(1'b0, OFF_STAT, 0);
    chk("state", rd[2:0], 1);
    sysref <= 1'b1;
    repeat (4) @(posedge hclk);
    sysref <= 1'b0;
    ahb(1'b0, OFF_STAT, 0);
    chk("state", rd[2:0], 2);
    @(negedge hclk);
    chk("comma", grp_a[9:0] inside {10'h0fa, 10'h305}, 1);
    chk("lane skew", grp_a[39:30], grp_a[9:0]);
    chk("pd", pd, 16'hfff0);
    hold = 1'b0;
    wait_data();
    ahb(1'b0, OFF_STAT, 0);
    chk("state", rd[2:0], 5);
    chk("rx release", rx_rel, 1);
    chk("k28.0", n_k0, 4);
    chk("k28.4", n_k4, 1);
    na = 0;
    repeat (8) begin
      @(negedge hclk);
      chk("f char", grp_a[9:0] inside {10'h0f8, 10'h307, 10'h0f3, 10'h30c}, 1);
      na += grp_a[9:0] inside {10'h0f3, 10'h30c};
    end
    chk("a count", na, 2);
    // sync request in mid-data, then relink
    hold = 1'b1;
    repeat (12) @(negedge hclk);
    ahb(1'b0, OFF_STAT, 0);
    chk("state", rd[2:0], 2);
    hold = 1'b0;
    wait_data();
    chk("k28.0", n_k0, 8);
    $display("subclass 1 test done");
    // disable, then subclass 0 with scrambling
    ahb(1'b1, OFF_CTRL, 32'h0003_0200);
    repeat (2) @(negedge hclk);
    chk("pd", pd, 16'hffff);
    chk("lane", grp_a[9:0], 0);
    ahb(1'b1, OFF_CTRL, 32'h0003_0203);
    wait_data();
    chk("k28.0", n_k0, 12);
    na = 0;
    repeat (8) begin
      @(negedge hclk);
      na += grp_a[9:0] inside {10'h0f8, 10'h307, 10'h0f3, 10'h30c};
    end
    chk("scrambled", na < 8, 1);
    ahb(1'b0, OFF_STAT, 0);
    chk("state", rd[2:0], 5);
    rnd_on = 1'b1;
    repeat (200) @(negedge hclk);
    ahb(1'b0, OFF_STAT, 0);
    chk("state", rd[2:0], 5);
    $display("subclass 0 test done");
    wrap_up();
  end
endmodule : jtx_link_tx_tb_top
bind jtx_link_tx jtx_chk #(.LANES(LANES)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .sync_request_single_ended_n(sync_request_single_ended_n), .sample_ready(sample_ready),
  .lane_group_a(lane_group_a), .serializer_pd(serializer_pd), .serializer_preemphasis(serializer_preemphasis));
`default_nettype wire

// File: testbench/jtx_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// receiver stand-in on lane 0; its own lmfc phase is arbitrary on purpose
module jtx_rx_model #(
  parameter int KLEN = 4,
  parameter int RBD = 0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hold,
  input wire logic [9:0] sym,
  output logic sync_n,
  output logic released
);
  int commas;
  int lmfc;
  logic arrived;
  // lane buffers from its first alignment start until the chosen release point
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      released <= 1'b0;
      arrived <= 1'b0;
    end else if (!sync_n) begin
      released <= 1'b0;
      arrived <= 1'b0;
    end else begin
      if (sym inside {10'h0f4, 10'h30b}) arrived <= 1'b1;
      if (arrived && lmfc == RBD) released <= 1'b1;
    end
  end
  // sync low while told to hold, release after four commas on an lmfc edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_n <= 1'b1;
      commas <= 0;
      lmfc <= 0;
    end else begin
      lmfc <= (lmfc + 1) % KLEN;
      if (hold) begin
        sync_n <= 1'b0;
        commas <= 0;
      end else if (!sync_n) begin
        commas <= (sym inside {10'h0fa, 10'h305}) ? commas + 1 : 0;
        if (commas >= 4 && lmfc == 0) begin
          sync_n <= 1'b1;
        end
      end
    end
  end
endmodule : jtx_rx_model
`default_nettype wire
